/* File: command_bus_owner_fifo_config.v */
// Register bank for command, bus ownership and queue configuration with its byte buffer
`timescale 1ns/10ps
`default_nettype none
`include "queue_regs_consts.vh"

module stage_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `STAGE_WORDS,
  parameter AW    = 2
) (
  input  wire             clk_in,
  input  wire             nrst_in,
  input  wire             clear_in,
  input  wire [WIDTH-1:0] in_data_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  output wire [WIDTH-1:0] out_data_out,
  output wire             out_valid_out,
  input  wire             out_ready_in
);
  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign in_ready_out  = (count_r != DEPTH[AW:0]);
  assign out_valid_out = (count_r != {(AW+1){1'b0}});
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else if (clear_in) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      count_r <= count_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule // stage_fifo

module command_bus_owner_fifo_config (
  input  wire       clk_in,
  input  wire       nrst_in,
  input  wire [7:0] reg_addr_in,
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  input  wire [7:0] reg_wdata_in,
  output wire       reg_wready_out,
  output reg  [7:0] reg_rdata_out,
  output reg        reg_rvalid_out,
  input  wire       command_done_in,
  output wire       standby_out,
  output wire       rf_frontend_off_out,
  output wire [4:0] command_code_out,
  output reg        command_start_out,
  output wire       host_owns_bus_out,
  output wire       module_owns_bus_out,
  output wire [1:0] coproc_link_select_out,
  output wire       near_full_flag_out,
  output wire       near_empty_flag_out,
  output wire [9:0] fill_count_out
);
  reg        standby_r;
  reg        rf_off_r;
  reg  [4:0] command_r;
  reg        unlock_r;
  reg        host_r;
  reg        module_r;
  reg  [1:0] link_r;
  reg        depth_sel_r;
  reg        thr_bit8_r;
  reg  [7:0] thr_low_r;
  reg  [7:0] queue_mem_r [0:`QUEUE_WORDS-1];
  reg  [8:0] q_wr_ptr_r;
  reg  [8:0] q_rd_ptr_r;
  reg  [9:0] count_r;
  reg  [7:0] rdata_nxt;

  wire       wr_cmd;
  wire       wr_boc;
  wire       wr_qcf;
  wire       wr_thr;
  wire       wr_port;
  wire       rd_port;
  wire       flush;
  wire [9:0] depth;
  wire [9:0] threshold;
  wire       near_full;
  wire       near_empty;
  wire       q_full;
  wire       q_empty;
  wire       q_pop;
  wire       q_push;
  wire [7:0] stage_data;
  wire       stage_valid;
  wire       stage_in_ready;

  assign wr_cmd  = reg_wr_in && (reg_addr_in == `OFS_COMMAND_SELECT);
  assign wr_boc  = reg_wr_in && (reg_addr_in == `OFS_BUS_OWNER_CONTROL);
  assign wr_qcf  = reg_wr_in && (reg_addr_in == `OFS_QUEUE_CONFIG);
  assign wr_thr  = reg_wr_in && (reg_addr_in == `OFS_QUEUE_THRESHOLD);
  assign wr_port = reg_wr_in && (reg_addr_in == `OFS_QUEUE_PORT);
  assign rd_port = reg_rd_in && (reg_addr_in == `OFS_QUEUE_PORT);
  assign flush   = wr_qcf & reg_wdata_in[`QCF_CLEAR_BIT];

  // Depth select chooses the usable size of the same memory
  assign depth      = depth_sel_r ? `DEPTH_SMALL : `DEPTH_LARGE;
  assign threshold  = {1'b0, thr_bit8_r & ~depth_sel_r, thr_low_r};
  assign near_full  = ((depth - count_r) <= threshold);
  assign near_empty = (count_r <= threshold);
  assign q_full     = (count_r >= depth);
  assign q_empty    = (count_r == 10'h000);
  assign q_pop      = rd_port & ~q_empty;
  assign q_push     = stage_valid & ~q_full & ~q_pop;

  // Host writes are staged so a full buffer stalls the port instead of dropping bytes
  stage_fifo #(
    .WIDTH (8),
    .DEPTH (`STAGE_WORDS),
    .AW    (2)
  ) u_stage (
    .clk_in        (clk_in),
    .nrst_in       (nrst_in),
    .clear_in      (flush),
    .in_data_in    (reg_wdata_in),
    .in_valid_in   (wr_port),
    .in_ready_out  (stage_in_ready),
    .out_data_out  (stage_data),
    .out_valid_out (stage_valid),
    .out_ready_in  (q_push)
  );

  assign reg_wready_out         = stage_in_ready;
  assign standby_out            = standby_r;
  assign rf_frontend_off_out    = rf_off_r;
  assign command_code_out       = command_r;
  assign host_owns_bus_out      = host_r;
  assign module_owns_bus_out    = module_r;
  assign coproc_link_select_out = link_r;
  assign near_full_flag_out     = near_full;
  assign near_empty_flag_out    = near_empty;
  assign fill_count_out         = count_r;

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      standby_r         <= 1'b0;
      rf_off_r          <= 1'b0;
      command_r         <= `RST_COMMAND;
      command_start_out <= 1'b0;
    end else begin
      command_start_out <= wr_cmd;
      if (wr_cmd) begin
        standby_r <= reg_wdata_in[`CMD_STANDBY_BIT];
        rf_off_r  <= reg_wdata_in[`CMD_RF_OFF_BIT];
        command_r <= reg_wdata_in[`CMD_CODE_MSB:0];
      end else if (command_done_in) begin
        command_r <= `RST_COMMAND;
      end
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      unlock_r <= 1'b0;
      host_r   <= 1'b0;
      module_r <= 1'b0;
      link_r   <= `RST_LINK_SELECT;
    end else if (wr_boc) begin
      link_r <= reg_wdata_in[`BOC_LINK_MSB:`BOC_LINK_LSB];
      if (unlock_r) begin
        unlock_r <= 1'b0;
        // Both owners at once is refused and leaves ownership as it was
        if (!(reg_wdata_in[`BOC_HOST_BIT] && reg_wdata_in[`BOC_MODULE_BIT])) begin
          host_r   <= reg_wdata_in[`BOC_HOST_BIT];
          module_r <= reg_wdata_in[`BOC_MODULE_BIT];
        end
      end else begin
        unlock_r <= reg_wdata_in[`BOC_UNLOCK_BIT];
      end
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      depth_sel_r <= 1'b0;
      thr_bit8_r  <= 1'b0;
      thr_low_r   <= 8'h00;
    end else begin
      if (wr_qcf) begin
        // No guard against resizing a non-empty buffer; software clears first
        depth_sel_r <= reg_wdata_in[`QCF_DEPTH_BIT];
        thr_bit8_r  <= reg_wdata_in[`QCF_THR_BIT8];
      end
      if (wr_thr) begin
        thr_low_r <= reg_wdata_in;
      end
    end
  end

  always @(posedge clk_in) begin
    if (q_push) begin
      queue_mem_r[q_wr_ptr_r] <= stage_data;
    end
  end

  // A read and a staged byte never move in the same cycle, so the count steps by one
  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q_wr_ptr_r <= 9'h000;
      q_rd_ptr_r <= 9'h000;
      count_r    <= 10'h000;
    end else if (flush) begin
      q_wr_ptr_r <= 9'h000;
      q_rd_ptr_r <= 9'h000;
      count_r    <= 10'h000;
    end else if (q_pop) begin
      q_rd_ptr_r <= q_rd_ptr_r + 9'h001;
      count_r    <= count_r - 10'h001;
    end else if (q_push) begin
      q_wr_ptr_r <= q_wr_ptr_r + 9'h001;
      count_r    <= count_r + 10'h001;
    end
  end

  always @* begin
    rdata_nxt = 8'h00;
    if (reg_addr_in == `OFS_COMMAND_SELECT) begin
      rdata_nxt = {standby_r, rf_off_r, 1'b0, command_r};
    end else if (reg_addr_in == `OFS_BUS_OWNER_CONTROL) begin
      rdata_nxt = {unlock_r, host_r, module_r, 1'b0, link_r, 2'b00};
    end else if (reg_addr_in == `OFS_QUEUE_CONFIG) begin
      rdata_nxt = {depth_sel_r, near_full, near_empty, 2'b00, thr_bit8_r,
                   count_r[9:8]};
    end else if (reg_addr_in == `OFS_QUEUE_THRESHOLD) begin
      rdata_nxt = thr_low_r;
    end else if (reg_addr_in == `OFS_FILL_COUNT) begin
      rdata_nxt = count_r[7:0];
    end else if (reg_addr_in == `OFS_QUEUE_PORT) begin
      rdata_nxt = q_empty ? 8'h00 : queue_mem_r[q_rd_ptr_r];
    end
  end

  always @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out  <= 8'h00;
      reg_rvalid_out <= 1'b0;
    end else begin
      reg_rvalid_out <= reg_rd_in;
      if (reg_rd_in) begin
        reg_rdata_out <= rdata_nxt;
      end
    end
  end
endmodule // command_bus_owner_fifo_config
`default_nettype wire

/* File: host_model.sv */
// Host controller model driving the register strobes
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic       clk_in,
  input  wire logic       wready_in,
  input  wire logic       rvalid_in,
  input  wire logic [7:0] rdata_in,
  output var  logic [7:0] addr_out = 8'h00,
  output var  logic       wr_out = 1'b0,
  output var  logic       rd_out = 1'b0,
  output var  logic [7:0] wdata_out = 8'h00
);
  // Called just after an edge; returns just after the edge that took it
  // One edge passes first so a strobe is never dropped and raised in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    #1;
    while (a == 8'h05 && !wready_in && n < 64) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (n == 64) tb_top.hang();
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1 wr_out = 1'b0;
    // Released lines show the inverse so a stale value never looks valid
    addr_out = ~a;
    wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1 rd_out = 1'b0;
    addr_out = ~a;
    while (!rvalid_in && n < 8) begin
      @(posedge clk_in);
      #1 n++;
    end
    if (n == 8) tb_top.hang();
    d = rdata_in;
  endtask
endmodule // host_model
`default_nettype wire

/* File: queue_regs_assertions.sv */
// Checker for the command, bus-owner and queue configuration bank
`timescale 1ns/10ps
`default_nettype none
module queue_regs_checker (
  input wire logic       clk_in,
  input wire logic       nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       standby_out,
  input wire logic       rf_frontend_off_out,
  input wire logic [4:0] command_code_out,
  input wire logic       command_start_out,
  input wire logic       host_owns_bus_out,
  input wire logic       module_owns_bus_out,
  input wire logic [1:0] coproc_link_select_out,
  input wire logic [9:0] fill_count_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire w0 = reg_wr_in && reg_addr_in == 8'h00;
  wire w1 = reg_wr_in && reg_addr_in == 8'h01;
  wire w2 = reg_wr_in && reg_addr_in == 8'h02 && reg_wdata_in[4];
  // Model of the unlock bit, so a locked write that moves ownership is caught
  logic unlk_r;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      unlk_r <= 1'b0;
    end else if (w1) begin
      unlk_r <= unlk_r ? 1'b0 : reg_wdata_in[7];
    end
  end
  property p_start; w0 |=> command_start_out; endproperty
  a_start: assert property (p_start) else $error("no start pulse");
  property p_code; w0 |=> command_code_out == $past(reg_wdata_in[4:0]); endproperty
  a_code: assert property (p_code) else $error("command code not taken");
  property p_power; w0 |=> standby_out == $past(reg_wdata_in[7])
    && rf_frontend_off_out == $past(reg_wdata_in[6]); endproperty
  a_power: assert property (p_power) else $error("power bits not taken");
  property p_excl; !(host_owns_bus_out && module_owns_bus_out); endproperty
  a_excl: assert property (p_excl) else $error("both bus owners set");
  // Ownership may only move on a bus-owner write
  property p_lock; $changed({host_owns_bus_out, module_owns_bus_out}) |->
    $past(w1 && unlk_r); endproperty
  a_lock: assert property (p_lock) else $error("ownership moved");
  property p_link; w1 |=> coproc_link_select_out == $past(reg_wdata_in[3:2]); endproperty
  a_link: assert property (p_link) else $error("link select not taken");
  property p_step; $changed(fill_count_out) && !$past(w2) |->
    fill_count_out - $past(fill_count_out) inside {10'h001, 10'h3ff}; endproperty
  a_step: assert property (p_step) else $error("count jumped");
  property p_flush; w2 |=> fill_count_out == 10'h000; endproperty
  a_flush: assert property (p_flush) else $error("clear left bytes");
endmodule // queue_regs_checker
`default_nettype wire

/* File: queue_regs_consts.vh */
// Constants for the command, bus-owner and queue configuration register bank
`ifndef QUEUE_REGS_CONSTS_VH
`define QUEUE_REGS_CONSTS_VH

`define OFS_COMMAND_SELECT    8'h00
`define OFS_BUS_OWNER_CONTROL 8'h01
`define OFS_QUEUE_CONFIG      8'h02
`define OFS_QUEUE_THRESHOLD   8'h03
`define OFS_FILL_COUNT        8'h04
`define OFS_QUEUE_PORT        8'h05

`define CMD_STANDBY_BIT       7
`define CMD_RF_OFF_BIT        6
`define CMD_CODE_MSB          4

`define BOC_UNLOCK_BIT        7
`define BOC_HOST_BIT          6
`define BOC_MODULE_BIT        5
`define BOC_LINK_MSB          3
`define BOC_LINK_LSB          2

`define QCF_DEPTH_BIT         7
`define QCF_NEAR_FULL_BIT     6
`define QCF_NEAR_EMPTY_BIT    5
`define QCF_CLEAR_BIT         4
`define QCF_THR_BIT8          2

`define LINK_OFF              2'h0
`define LINK_SPI              2'h1
`define LINK_LOW_SPEED_TWOWIRE 2'h2
`define LINK_TWOWIRE          2'h3

`define DEPTH_SMALL           10'h0ff
`define DEPTH_LARGE           10'h200
`define QUEUE_WORDS           512
`define STAGE_WORDS           4

`define RST_COMMAND           5'h00
`define RST_LINK_SELECT       2'h0
`define RST_THRESHOLD         9'h000

`endif

/* File: tb_top.sv */
// Self-checking bench for the command, bus-owner and queue bank
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic       clk_in = 1'b0;
  logic       nrst_in = 1'b0;
  logic       done_r = 1'b0;
  wire  [7:0] addr, wdata, rdata;
  wire        wr, rd, wrdy, rvalid, stby, rfoff, start, host, modl, nf, ne;
  wire  [4:0] code;
  wire  [1:0] link;
  wire  [9:0] cnt;
  int         n_mismatch = 0;
  int         n_tests = 0;
  logic [7:0] d;
  logic [7:0] bw [8];
  logic [7:0] be [8];
  always #4 clk_in = ~clk_in;
  host_model u_host (.clk_in(clk_in), .wready_in(wrdy), .rvalid_in(rvalid), .rdata_in(rdata),
    .addr_out(addr), .wr_out(wr), .rd_out(rd), .wdata_out(wdata));
  command_bus_owner_fifo_config u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_wready_out(wrdy),
    .reg_rdata_out(rdata), .reg_rvalid_out(rvalid), .command_done_in(done_r),
    .standby_out(stby), .rf_frontend_off_out(rfoff), .command_code_out(code),
    .command_start_out(start), .host_owns_bus_out(host), .module_owns_bus_out(modl),
    .coproc_link_select_out(link), .near_full_flag_out(nf), .near_empty_flag_out(ne),
    .fill_count_out(cnt));
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    u_host.rd(a, d);
    chk({2'h0, d}, {2'h0, e});
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wrap_up;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    wrap_up();
  endtask
  initial begin
    bw = '{8'h40, 8'h80, 8'h4c, 8'h80, 8'h60, 8'h80, 8'h24, 8'h08};
    be = '{8'h00, 8'h80, 8'h4c, 8'hc0, 8'h40, 8'hc0, 8'h24, 8'h28};
    idle(12);
    nrst_in = 1'b1;
    for (int i = 0; i < 5; i++) rchk(i[7:0], i == 2 ? 8'h20 : 8'h00);
    rchk(8'h10, 8'h00);
    u_host.wr(8'h00, 8'he5);
    chk({9'h0, start}, 10'h001);
    chk({stby, rfoff, 3'h0, code}, {2'b11, 3'h0, 5'h05});
    rchk(8'h00, 8'hc5);
    done_r = 1'b1;
    idle(1);
    done_r = 1'b0;
    chk({5'h0, code}, 10'h000);
    foreach (bw[i]) begin
      u_host.wr(8'h01, bw[i]);
      rchk(8'h01, be[i]);
    end
    chk({6'h0, host, modl, link}, 10'h006);
    u_host.wr(8'h03, 8'h02);
    rchk(8'h03, 8'h02);
    for (int i = 0; i < 3; i++) u_host.wr(8'h05, 8'ha1 + i[7:0]);
    idle(2);
    rchk(8'h04, 8'h03);
    rchk(8'h02, 8'h00);
    rchk(8'h05, 8'ha1);
    rchk(8'h02, 8'h20);
    chk({8'h0, nf, ne}, 10'h001);
    rchk(8'h04, 8'h02);
    u_host.wr(8'h03, 8'hff);
    u_host.wr(8'h02, 8'h14);
    rchk(8'h02, 8'h24);
    for (int i = 0; i < 256; i++) u_host.wr(8'h05, i[7:0]);
    idle(2);
    rchk(8'h02, 8'h65);
    chk({8'h0, nf, ne}, 10'h003);
    rchk(8'h04, 8'h00);
    // The buffer is cleared before the depth changes
    u_host.wr(8'h02, 8'h10);
    u_host.wr(8'h03, 8'h00);
    u_host.wr(8'h02, 8'h84);
    rchk(8'h02, 8'ha4);
    for (int i = 0; i < 256; i++) u_host.wr(8'h05, i[7:0]);
    idle(2);
    rchk(8'h02, 8'hc4);
    chk({8'h0, nf, ne}, 10'h002);
    rchk(8'h04, 8'hff);
    // The byte past the full buffer waits in staging; three more fill it
    for (int i = 0; i < 3; i++) u_host.wr(8'h05, 8'h5a);
    chk({9'h0, wrdy}, 10'h000);
    u_host.wr(8'h02, 8'h94);
    chk(cnt, 10'h000);
    chk({9'h0, wrdy}, 10'h001);
    rchk(8'h05, 8'h00);
    chk(cnt, 10'h000);
    wrap_up();
  end
endmodule // tb_top
bind command_bus_owner_fifo_config queue_regs_checker u_chk (.clk_in(clk_in),
  .nrst_in(nrst_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
  .reg_wdata_in(reg_wdata_in), .standby_out(standby_out),
  .rf_frontend_off_out(rf_frontend_off_out), .command_code_out(command_code_out),
  .command_start_out(command_start_out), .host_owns_bus_out(host_owns_bus_out),
  .module_owns_bus_out(module_owns_bus_out),
  .coproc_link_select_out(coproc_link_select_out), .fill_count_out(fill_count_out));
`default_nettype wire
